// ---- hdl/clk_ctrl_pkg.sv ----
// Constants, types and helpers shared by the main clock controller
package clk_ctrl_pkg;

	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [5:0] IDX_CTRL_A   = 6'h00;
	localparam logic [5:0] IDX_CTRL_B   = 6'h01;
	localparam logic [5:0] IDX_LOCK     = 6'h02;
	localparam logic [5:0] IDX_STATUS   = 6'h03;
	localparam logic [5:0] IDX_FAST_CTL = 6'h10;
	localparam logic [5:0] IDX_FAST_CLA = 6'h11;
	localparam logic [5:0] IDX_FAST_CLB = 6'h12;
	localparam logic [5:0] IDX_SLOW_CTL = 6'h18;
	localparam logic [5:0] IDX_XOSC_CTL = 6'h1c;
	localparam logic [5:0] IDX_GUARD    = 6'h20;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int PIN_OUT_BIT   = 7;
	localparam int SRC_LSB       = 0;
	localparam int DIV_LSB       = 1;
	localparam int DIV_ON_BIT    = 0;
	localparam int FREEZE_BIT    = 0;
	localparam int EXT_ST_BIT    = 7;
	localparam int XTAL_ST_BIT   = 6;
	localparam int SLOW_ST_BIT   = 5;
	localparam int FAST_ST_BIT   = 4;
	localparam int PENDING_BIT   = 0;
	localparam int STDBY_BIT     = 1;
	localparam int ENABLE_BIT    = 0;
	localparam int XSEL_BIT      = 2;
	localparam int XSUT_LSB      = 4;
	localparam int FUSE_LOCK_BIT = 7;

	// ************************************************************
	// Reset values and key
	// ************************************************************
	localparam logic [7:0] CTRL_B_RESET = 8'h11;
	// Unlock key value is arbitrary
	localparam logic [7:0] UNLOCK_KEY   = 8'h3c;
	localparam logic [2:0] GUARD_WINDOW = 3'h4;

	// ************************************************************
	// Oscillator timing, counted in oscillator cycles
	// ************************************************************
	localparam logic [2:0]  GATE_CYCLES   = 3'h4;
	localparam logic [2:0]  EXT_CYCLES    = 3'h2;
	localparam logic [16:0] XSUT_1K       = 17'h00400;
	localparam logic [16:0] XSUT_16K      = 17'h04000;
	localparam logic [16:0] XSUT_32K      = 17'h08000;
	localparam logic [16:0] XSUT_64K      = 17'h10000;
	localparam logic [16:0] XEXT_STARTUP  = 17'h00002;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		SRC_FAST    = 2'b00,
		SRC_SLOW    = 2'b01,
		SRC_CRYSTAL = 2'b10,
		SRC_EXT     = 2'b11
	} src_e;

	typedef struct packed {
		logic [1:0] startup;
		logic       sel;
		logic       stdby;
		logic       enable;
	} xosc_cfg_s;

	// ************************************************************
	// Division helpers
	// ************************************************************
	function automatic logic div_code_valid(input logic [3:0] code);
		return (code <= 4'h5) || ((code >= 4'h8) && (code <= 4'hc));
	endfunction

	// Half ratio: peripheral clock toggles every this many main rising edges
	function automatic logic [5:0] div_half(input logic [3:0] code);
		logic [5:0] h;
		h = 6'h01;
		case (code)
			4'h0: h = 6'h01;
			4'h1: h = 6'h02;
			4'h2: h = 6'h04;
			4'h3: h = 6'h08;
			4'h4: h = 6'h10;
			4'h5: h = 6'h20;
			4'h8: h = 6'h03;
			4'h9: h = 6'h05;
			4'ha: h = 6'h06;
			4'hb: h = 6'h0c;
			4'hc: h = 6'h18;
			default: h = 6'h01;
		endcase
		return h;
	endfunction

endpackage

// ---- hdl/main_clock_select_prescale.sv ----
// Main clock source selection, prescaler, lock and status registers
//
// Functional notes
// - Clock-out bit drives system clock to pin
// - Pin silent in sleep unless peripheral uses clock
// - Two-bit field selects one of four sources
// - Division codes map to documented ratios
// - Divider off passes main clock undivided
// - Division code writable at run time
// - Control B resets to 0x11
// - Freeze bit locks control A, B; calibration only while fast source active
// - Lock register frozen until hardware reset
// - External status high once input started
// - Stable bits only when source requested
// - Pending bit while switch awaits stability
// - Standby keep-running opens gate after four cycles, two for crystal
// - Crystal start-up wait from field, two cycles for external
// - Crystal select, start-up locked while running
`timescale 1ns/100ps
`default_nettype none

module main_clock_select_prescale (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Oscillator sources, indexed by source code
	input  wire logic [3:0]  osc_clk_i,
	input  wire logic [3:0]  osc_ready_i,
	output logic      [3:0]  osc_enable_o,
	// System side
	input  wire logic [3:0]  periph_request_i,
	input  wire logic        sleep_i,
	input  wire logic        periph_uses_sysclk_i,
	// Factory calibration values
	input  wire logic [5:0]  fuse_trim_i,
	input  wire logic [3:0]  fuse_slope_i,
	input  wire logic        fuse_cal_lock_i,
	// Clock outputs
	output logic             main_clock_o,
	output logic             peripheral_clock_o,
	output logic             sysclk_pin_out_o,
	output logic      [1:0]  main_source_o
);

	// ************************************************************
	// Synchronisers for oscillator levels and ready flags
	// ************************************************************
	logic [3:0] clk_meta_ff;
	logic [3:0] clk_sync_ff;
	logic [3:0] clk_prev_ff;
	logic [3:0] rdy_meta_ff;
	logic [3:0] rdy_sync_ff;
	logic [3:0] osc_rise;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_meta_ff <= 4'h0;
			clk_sync_ff <= 4'h0;
			clk_prev_ff <= 4'h0;
			rdy_meta_ff <= 4'h0;
			rdy_sync_ff <= 4'h0;
		end else begin
			clk_meta_ff <= osc_clk_i;
			clk_sync_ff <= clk_meta_ff;
			clk_prev_ff <= clk_sync_ff;
			rdy_meta_ff <= osc_ready_i;
			rdy_sync_ff <= rdy_meta_ff;
		end
	end

	assign osc_rise = clk_sync_ff & ~clk_prev_ff;

	// ************************************************************
	// Register state
	// ************************************************************
	logic                        ack_ff;
	logic [31:0]                 rdata_ff;
	logic [2:0]                  guard_cnt_ff;
	logic                        pin_out_en_ff;
	clk_ctrl_pkg::src_e          target_src_ff;
	clk_ctrl_pkg::src_e          active_src_ff;
	logic [3:0]                  division_code_ff;
	logic                        divider_on_ff;
	logic                        settings_freeze_ff;
	logic                        fast_stdby_ff;
	logic                        slow_stdby_ff;
	logic [5:0]                  fast_osc_trim_ff;
	logic [3:0]                  fast_osc_temp_slope_ff;
	logic                        fuse_lock_ff;
	clk_ctrl_pkg::xosc_cfg_s     xosc_cfg_ff;
	logic [3:0]                  stable;

	logic        req;
	logic        wr;
	logic [5:0]  idx;
	logic [7:0]  wdat;
	logic        guard_open;
	logic        cal_locked;
	logic        pending;

	assign req        = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr         = req & wb_we_i & wb_sel_i[0];
	assign idx        = wb_adr_i[7:2];
	assign wdat       = wb_dat_i[7:0];
	assign guard_open = (guard_cnt_ff != 3'h0);
	assign cal_locked = fuse_lock_ff | (settings_freeze_ff & (active_src_ff == clk_ctrl_pkg::SRC_FAST));
	assign pending    = (target_src_ff != active_src_ff);

	// ************************************************************
	// Bus handshake
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req;
		end
	end

	// Key opens a window of a few bus accesses, standing in for instructions
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			guard_cnt_ff <= 3'h0;
		end else if (wr && idx == clk_ctrl_pkg::IDX_GUARD && wdat == clk_ctrl_pkg::UNLOCK_KEY) begin
			guard_cnt_ff <= clk_ctrl_pkg::GUARD_WINDOW;
		end else if (req && guard_open) begin
			guard_cnt_ff <= guard_cnt_ff - 3'h1;
		end
	end

	// ************************************************************
	// Main control A and B
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_out_en_ff <= 1'b0;
			target_src_ff <= clk_ctrl_pkg::SRC_FAST;
		end else if (wr && idx == clk_ctrl_pkg::IDX_CTRL_A && guard_open && !settings_freeze_ff) begin
			pin_out_en_ff <= wdat[clk_ctrl_pkg::PIN_OUT_BIT];
			target_src_ff <= clk_ctrl_pkg::src_e'(wdat[clk_ctrl_pkg::SRC_LSB +: 2]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			divider_on_ff    <= clk_ctrl_pkg::CTRL_B_RESET[clk_ctrl_pkg::DIV_ON_BIT];
			division_code_ff <= clk_ctrl_pkg::CTRL_B_RESET[clk_ctrl_pkg::DIV_LSB +: 4];
		end else if (wr && idx == clk_ctrl_pkg::IDX_CTRL_B && guard_open && !settings_freeze_ff) begin
			divider_on_ff <= wdat[clk_ctrl_pkg::DIV_ON_BIT];
			// Reserved codes leave the running ratio in place
			if (clk_ctrl_pkg::div_code_valid(wdat[clk_ctrl_pkg::DIV_LSB +: 4])) begin
				division_code_ff <= wdat[clk_ctrl_pkg::DIV_LSB +: 4];
			end
		end
	end

	// Only a reset clears the freeze
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			settings_freeze_ff <= 1'b0;
		end else if (wr && idx == clk_ctrl_pkg::IDX_LOCK && guard_open && !settings_freeze_ff) begin
			settings_freeze_ff <= wdat[clk_ctrl_pkg::FREEZE_BIT];
		end
	end

	// ************************************************************
	// Oscillator control and calibration
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_stdby_ff <= 1'b0;
			slow_stdby_ff <= 1'b0;
		end else if (wr && guard_open) begin
			if (idx == clk_ctrl_pkg::IDX_FAST_CTL) begin
				fast_stdby_ff <= wdat[clk_ctrl_pkg::STDBY_BIT];
			end else if (idx == clk_ctrl_pkg::IDX_SLOW_CTL) begin
				slow_stdby_ff <= wdat[clk_ctrl_pkg::STDBY_BIT];
			end
		end
	end

	// Factory values come from the fuse loader on the same clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_osc_trim_ff       <= fuse_trim_i;
			fast_osc_temp_slope_ff <= fuse_slope_i;
			fuse_lock_ff           <= fuse_cal_lock_i;
		end else if (wr && guard_open && !cal_locked) begin
			if (idx == clk_ctrl_pkg::IDX_FAST_CLA) begin
				fast_osc_trim_ff <= wdat[5:0];
			end else if (idx == clk_ctrl_pkg::IDX_FAST_CLB) begin
				fast_osc_temp_slope_ff <= wdat[3:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xosc_cfg_ff <= '0;
		end else if (wr && idx == clk_ctrl_pkg::IDX_XOSC_CTL && guard_open) begin
			xosc_cfg_ff.stdby  <= wdat[clk_ctrl_pkg::STDBY_BIT];
			xosc_cfg_ff.enable <= wdat[clk_ctrl_pkg::ENABLE_BIT];
			if (!xosc_cfg_ff.enable && !stable[clk_ctrl_pkg::SRC_CRYSTAL]) begin
				xosc_cfg_ff.sel     <= wdat[clk_ctrl_pkg::XSEL_BIT];
				xosc_cfg_ff.startup <= wdat[clk_ctrl_pkg::XSUT_LSB +: 2];
			end
		end
	end

	// ************************************************************
	// Source request, start-up and gate counters
	// ************************************************************
	logic [3:0]  requested;
	logic [3:0]  running;
	logic [16:0] warm_cnt_ff [4];
	logic [2:0]  gate_cnt_ff [4];
	logic [16:0] warm_target [4];
	logic [2:0]  gate_target [4];

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			requested[i] = (active_src_ff == i[1:0]) || (target_src_ff == i[1:0]) || periph_request_i[i];
		end
		running[clk_ctrl_pkg::SRC_FAST]    = requested[clk_ctrl_pkg::SRC_FAST] | fast_stdby_ff;
		running[clk_ctrl_pkg::SRC_SLOW]    = requested[clk_ctrl_pkg::SRC_SLOW] | slow_stdby_ff;
		running[clk_ctrl_pkg::SRC_CRYSTAL] = xosc_cfg_ff.enable
			& (requested[clk_ctrl_pkg::SRC_CRYSTAL] | xosc_cfg_ff.stdby);
		running[clk_ctrl_pkg::SRC_EXT]     = requested[clk_ctrl_pkg::SRC_EXT];
		// Fast, slow and external sources: ready flag is the whole warm-up
		warm_target[clk_ctrl_pkg::SRC_FAST] = 17'h0;
		warm_target[clk_ctrl_pkg::SRC_SLOW] = 17'h0;
		warm_target[clk_ctrl_pkg::SRC_EXT]  = 17'h0;
		case (xosc_cfg_ff.startup)
			2'h0: warm_target[clk_ctrl_pkg::SRC_CRYSTAL] = clk_ctrl_pkg::XSUT_1K;
			2'h1: warm_target[clk_ctrl_pkg::SRC_CRYSTAL] = clk_ctrl_pkg::XSUT_16K;
			2'h2: warm_target[clk_ctrl_pkg::SRC_CRYSTAL] = clk_ctrl_pkg::XSUT_32K;
			default: warm_target[clk_ctrl_pkg::SRC_CRYSTAL] = clk_ctrl_pkg::XSUT_64K;
		endcase
		if (xosc_cfg_ff.sel) begin
			warm_target[clk_ctrl_pkg::SRC_CRYSTAL] = clk_ctrl_pkg::XEXT_STARTUP;
		end
		gate_target[clk_ctrl_pkg::SRC_FAST]    = clk_ctrl_pkg::GATE_CYCLES;
		gate_target[clk_ctrl_pkg::SRC_SLOW]    = clk_ctrl_pkg::GATE_CYCLES;
		gate_target[clk_ctrl_pkg::SRC_CRYSTAL] = clk_ctrl_pkg::EXT_CYCLES;
		gate_target[clk_ctrl_pkg::SRC_EXT]     = clk_ctrl_pkg::EXT_CYCLES;
		for (int i = 0; i < 4; i++) begin
			stable[i] = requested[i] && (warm_cnt_ff[i] >= warm_target[i])
				&& (gate_cnt_ff[i] >= gate_target[i]);
		end
	end

	// Warm-up survives while the source keeps running, so standby skips it
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (rst_i || !running[i] || !rdy_sync_ff[i]) begin
				warm_cnt_ff[i] <= 17'h0;
			end else if (osc_rise[i] && warm_cnt_ff[i] < warm_target[i]) begin
				warm_cnt_ff[i] <= warm_cnt_ff[i] + 17'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (rst_i || !requested[i] || warm_cnt_ff[i] < warm_target[i] || !rdy_sync_ff[i]) begin
				gate_cnt_ff[i] <= 3'h0;
			end else if (osc_rise[i] && gate_cnt_ff[i] < gate_target[i]) begin
				gate_cnt_ff[i] <= gate_cnt_ff[i] + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_enable_o <= 4'h0;
		end else begin
			osc_enable_o <= running;
		end
	end

	// ************************************************************
	// Glitch-free source switch
	// ************************************************************
	// Hand over only while both clocks are low, so no pulse is cut short
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_src_ff <= clk_ctrl_pkg::SRC_FAST;
		end else if (pending && stable[target_src_ff]
			&& !clk_sync_ff[active_src_ff] && !clk_sync_ff[target_src_ff]) begin
			active_src_ff <= target_src_ff;
		end
	end

	// ************************************************************
	// Prescaler and clock outputs
	// ************************************************************
	logic [5:0] div_cnt_ff;
	logic       main_level;
	logic [5:0] half;

	assign main_level = clk_sync_ff[active_src_ff];
	assign half       = clk_ctrl_pkg::div_half(division_code_ff);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt_ff         <= 6'h0;
			peripheral_clock_o <= 1'b0;
		end else if (!divider_on_ff) begin
			div_cnt_ff         <= 6'h0;
			peripheral_clock_o <= main_level;
		end else if (osc_rise[active_src_ff]) begin
			if (div_cnt_ff + 6'h1 >= half) begin
				div_cnt_ff         <= 6'h0;
				peripheral_clock_o <= ~peripheral_clock_o;
			end else begin
				div_cnt_ff <= div_cnt_ff + 6'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_clock_o     <= 1'b0;
			sysclk_pin_out_o <= 1'b0;
			main_source_o    <= 2'h0;
		end else begin
			main_clock_o     <= main_level;
			sysclk_pin_out_o <= pin_out_en_ff && (!sleep_i || periph_uses_sysclk_i) && main_level;
			main_source_o    <= active_src_ff;
		end
	end

	// ************************************************************
	// Read data
	// ************************************************************
	logic [7:0] rbyte;

	always_comb begin
		rbyte = 8'h0;
		if (idx == clk_ctrl_pkg::IDX_CTRL_A) begin
			rbyte[clk_ctrl_pkg::PIN_OUT_BIT]     = pin_out_en_ff;
			rbyte[clk_ctrl_pkg::SRC_LSB +: 2]    = target_src_ff;
		end else if (idx == clk_ctrl_pkg::IDX_CTRL_B) begin
			rbyte[clk_ctrl_pkg::DIV_LSB +: 4]    = division_code_ff;
			rbyte[clk_ctrl_pkg::DIV_ON_BIT]      = divider_on_ff;
		end else if (idx == clk_ctrl_pkg::IDX_LOCK) begin
			rbyte[clk_ctrl_pkg::FREEZE_BIT]      = settings_freeze_ff;
		end else if (idx == clk_ctrl_pkg::IDX_STATUS) begin
			rbyte[clk_ctrl_pkg::EXT_ST_BIT]      = stable[clk_ctrl_pkg::SRC_EXT];
			rbyte[clk_ctrl_pkg::XTAL_ST_BIT]     = stable[clk_ctrl_pkg::SRC_CRYSTAL];
			rbyte[clk_ctrl_pkg::SLOW_ST_BIT]     = stable[clk_ctrl_pkg::SRC_SLOW];
			rbyte[clk_ctrl_pkg::FAST_ST_BIT]     = stable[clk_ctrl_pkg::SRC_FAST];
			rbyte[clk_ctrl_pkg::PENDING_BIT]     = pending;
		end else if (idx == clk_ctrl_pkg::IDX_FAST_CTL) begin
			rbyte[clk_ctrl_pkg::STDBY_BIT]       = fast_stdby_ff;
		end else if (idx == clk_ctrl_pkg::IDX_FAST_CLA) begin
			rbyte[5:0]                           = fast_osc_trim_ff;
		end else if (idx == clk_ctrl_pkg::IDX_FAST_CLB) begin
			rbyte[clk_ctrl_pkg::FUSE_LOCK_BIT]   = fuse_lock_ff;
			rbyte[3:0]                           = fast_osc_temp_slope_ff;
		end else if (idx == clk_ctrl_pkg::IDX_SLOW_CTL) begin
			rbyte[clk_ctrl_pkg::STDBY_BIT]       = slow_stdby_ff;
		end else if (idx == clk_ctrl_pkg::IDX_XOSC_CTL) begin
			rbyte[clk_ctrl_pkg::XSUT_LSB +: 2]   = xosc_cfg_ff.startup;
			rbyte[clk_ctrl_pkg::XSEL_BIT]        = xosc_cfg_ff.sel;
			rbyte[clk_ctrl_pkg::STDBY_BIT]       = xosc_cfg_ff.stdby;
			rbyte[clk_ctrl_pkg::ENABLE_BIT]      = xosc_cfg_ff.enable;
		end else if (idx == clk_ctrl_pkg::IDX_GUARD) begin
			rbyte[2:0]                           = guard_cnt_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_ff <= 32'h0;
		end else if (req && !wb_we_i) begin
			rdata_ff <= {24'h0, rbyte};
		end else begin
			rdata_ff <= 32'h0;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;

endmodule

`default_nettype wire

// ---- verif/clk_ctrl_asserts.sv ----
// Port assertions for the main clock controller
`timescale 1ns/100ps
`default_nettype none
module clk_ctrl_asserts (
	// Clock and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Clock side
	input wire logic [3:0]  osc_enable_o,
	input wire logic        sleep_i,
	input wire logic        periph_uses_sysclk_i,
	input wire logic        sysclk_pin_out_o,
	input wire logic [1:0]  main_source_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ****************
	// Bus handshake
	// ****************
	a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	// ****************
	// Register content
	// ****************
	a_ctrl_rsvd: assert property (
		wb_ack_o && $past(!wb_we_i && wb_adr_i[7:2] == clk_ctrl_pkg::IDX_CTRL_A) |-> wb_dat_o[6:2] == 5'h00)
		else $error("reserved control bits set");
	a_status_rsvd: assert property (
		wb_ack_o && $past(!wb_we_i && wb_adr_i[7:2] == clk_ctrl_pkg::IDX_STATUS) |-> wb_dat_o[3:1] == 3'h0)
		else $error("reserved status bits set");
	a_stable_req: assert property (
		wb_ack_o && $past(!wb_we_i && wb_adr_i[7:2] == clk_ctrl_pkg::IDX_STATUS)
		|-> (wb_dat_o[7:4] & ~$past(osc_enable_o)) == 4'h0)
		else $error("stable bit for idle source");
	// ****************
	// Clock outputs
	// ****************
	a_sleep_quiet: assert property (
		(sleep_i && !periph_uses_sysclk_i) ##1 (sleep_i && !periph_uses_sysclk_i) |-> !sysclk_pin_out_o)
		else $error("clock pin active in sleep");
	a_reset_quiet: assert property (disable iff (1'b0)
		rst_i |=> !wb_ack_o && main_source_o == 2'h0 && !sysclk_pin_out_o)
		else $error("outputs active after reset");
endmodule
`default_nettype wire

// ---- verif/osc_model.sv ----
// Oscillator sources seen by the clock controller
`timescale 1ns/100ps
`default_nettype none
module osc_model (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Oscillator pins
	input wire logic  [3:0] osc_enable_i,
	output logic      [3:0] osc_clk_o,
	output logic      [3:0] osc_ready_o
);
	// Unequal rates so a wrong source choice shows up as a wrong period
	localparam int HALF [4] = '{2, 3, 5, 4};
	logic [3:0] cnt_ff [4];
	logic [3:0] warm_ff [4];
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			// Idle oscillators stand still low and lose readiness
			if (rst_i || !osc_enable_i[i]) begin
				osc_clk_o[i] <= 1'b0;
				osc_ready_o[i] <= 1'b0;
				cnt_ff[i] <= 4'h0;
				warm_ff[i] <= 4'h0;
			end else begin
				warm_ff[i] <= (warm_ff[i] == 4'h7) ? 4'h7 : warm_ff[i] + 4'h1;
				osc_ready_o[i] <= (warm_ff[i] == 4'h7);
				cnt_ff[i] <= (cnt_ff[i] == 4'(HALF[i] - 1)) ? 4'h0 : cnt_ff[i] + 4'h1;
				if (cnt_ff[i] == 4'(HALF[i] - 1)) begin
					osc_clk_o[i] <= ~osc_clk_o[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- verif/tb_main_clock_select_prescale.sv ----
// Self-checking bench for the main clock controller
`timescale 1ns/100ps
`default_nettype none
module tb_main_clock_select_prescale;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sleep_i, periph_uses_sysclk_i, fuse_cal_lock_i;
	logic main_clock_o, peripheral_clock_o, sysclk_pin_out_o;
	logic [7:0] wb_adr_i, q;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [3:0] wb_sel_i, osc_clk_i, osc_ready_i, osc_enable_o, periph_request_i, fuse_slope_i, code, cur, rmask;
	logic [5:0] fuse_trim_i;
	logic [1:0] main_source_o, s, old;
	int num_errors, total_checks, c, k;

	main_clock_select_prescale dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .osc_clk_i(osc_clk_i), .osc_ready_i(osc_ready_i), .osc_enable_o(osc_enable_o),
		.periph_request_i(periph_request_i), .sleep_i(sleep_i), .periph_uses_sysclk_i(periph_uses_sysclk_i),
		.fuse_trim_i(fuse_trim_i), .fuse_slope_i(fuse_slope_i), .fuse_cal_lock_i(fuse_cal_lock_i),
		.main_clock_o(main_clock_o), .peripheral_clock_o(peripheral_clock_o),
		.sysclk_pin_out_o(sysclk_pin_out_o), .main_source_o(main_source_o));
	osc_model u_osc (.clk_i(clk_i), .rst_i(rst_i), .osc_enable_i(osc_enable_o), .osc_clk_o(osc_clk_i),
		.osc_ready_o(osc_ready_i));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// ****************
	// Expectations
	// ****************
	function automatic logic valid(input logic [3:0] d);
		return (d <= 4'h5) || (d >= 4'h8 && d <= 4'hc);
	endfunction
	function automatic logic [7:0] ratio(input logic [3:0] d);
		logic [7:0] t [16] = '{2, 4, 8, 16, 32, 64, 0, 0, 6, 10, 12, 24, 48, 0, 0, 0};
		return t[d];
	endfunction
	// ****************
	// Tasks
	// ****************
	task check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task hang(input int n);
		if (n >= 3000) begin
			num_errors++;
			$display("unexpected at %0t: wait ran out", $time);
			close_out();
		end
	endtask
	// Classic single cycle: held until ack is sampled, then one idle cycle
	task xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
		k = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 3000);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
		hang(k);
	endtask
	task rdc(input logic [5:0] idx, input logic [7:0] e);
		xfer(1'b0, idx, 8'h00);
		check(q, e);
	endtask
	// Key write first; a bare write to a protected register is dropped
	task pw(input logic [5:0] idx, input logic [7:0] d);
		xfer(1'b1, clk_ctrl_pkg::IDX_GUARD, clk_ctrl_pkg::UNLOCK_KEY);
		xfer(1'b1, idx, d);
	endtask
	task do_reset;
		rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// Main clock rises between two peripheral clock rises
	task per_period(output int n);
		logic pm, pp;
		int r;
		n = 0;
		r = 0;
		k = 0;
		pm = main_clock_o;
		pp = peripheral_clock_o;
		while (r < 2 && k < 3000) begin
			@(posedge clk_i);
			k++;
			if (r == 1 && main_clock_o && !pm) n++;
			if (peripheral_clock_o && !pp) r++;
			pm = main_clock_o;
			pp = peripheral_clock_o;
		end
		hang(k);
	endtask
	task pin_edges(output int n);
		logic p;
		n = 0;
		repeat (3) @(posedge clk_i);
		p = sysclk_pin_out_o;
		repeat (40) begin
			@(posedge clk_i);
			if (sysclk_pin_out_o && !p) n++;
			p = sysclk_pin_out_o;
		end
	endtask
	// ****************
	// Main sequence
	// ****************
	initial begin
		void'($urandom(32'h03acefd8));
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, sleep_i, periph_uses_sysclk_i, fuse_cal_lock_i} = 7'h40;
		{wb_adr_i, wb_dat_i, periph_request_i} = '0;
		wb_sel_i = 4'h1;
		fuse_trim_i = 6'($urandom);
		fuse_slope_i = 4'($urandom);
		rmask = 4'($urandom);
		do_reset();
		rdc(clk_ctrl_pkg::IDX_CTRL_A, 8'h00);
		rdc(clk_ctrl_pkg::IDX_CTRL_B, 8'h11);
		rdc(clk_ctrl_pkg::IDX_LOCK, 8'h00);
		rdc(6'h04, 8'h00);
		rdc(clk_ctrl_pkg::IDX_FAST_CLA, {2'h0, fuse_trim_i});
		rdc(clk_ctrl_pkg::IDX_FAST_CLB, {4'h0, fuse_slope_i});
		xfer(1'b1, clk_ctrl_pkg::IDX_CTRL_B, 8'h00);
		rdc(clk_ctrl_pkg::IDX_CTRL_B, 8'h11);
		$display("reset and access test done");
		cur = 4'h8;
		for (int i = 0; i < 16; i++) begin
			code = 4'(i) ^ rmask;
			pw(clk_ctrl_pkg::IDX_CTRL_B, {3'h0, code, 1'b1});
			if (valid(code)) cur = code;
			rdc(clk_ctrl_pkg::IDX_CTRL_B, {3'h0, cur, 1'b1});
			per_period(c);
			per_period(c);
			check(8'(c), ratio(cur));
		end
		pw(clk_ctrl_pkg::IDX_CTRL_B, {3'h0, cur, 1'b0});
		per_period(c);
		per_period(c);
		check(8'(c), 8'h01);
		$display("prescaler test done");
		pw(clk_ctrl_pkg::IDX_XOSC_CTL, 8'h05);
		pw(clk_ctrl_pkg::IDX_XOSC_CTL, 8'h31);
		rdc(clk_ctrl_pkg::IDX_XOSC_CTL, 8'h05);
		old = 2'h0;
		for (int i = 1; i < 5; i++) begin
			s = 2'(i);
			pw(clk_ctrl_pkg::IDX_CTRL_A, {6'h0, s});
			rdc(clk_ctrl_pkg::IDX_STATUS, 8'h01 | (8'h10 << old));
			k = 0;
			while (main_source_o !== s && k < 3000) begin
				@(posedge clk_i);
				k++;
			end
			hang(k);
			rdc(clk_ctrl_pkg::IDX_STATUS, 8'h10 << s);
			old = s;
		end
		$display("source switch test done");
		pw(clk_ctrl_pkg::IDX_CTRL_A, 8'h80);
		pin_edges(c);
		check(8'(c != 0), 8'h01);
		sleep_i <= 1'b1;
		pin_edges(c);
		check(8'(c), 8'h00);
		periph_uses_sysclk_i <= 1'b1;
		pin_edges(c);
		check(8'(c != 0), 8'h01);
		sleep_i <= 1'b0;
		pw(clk_ctrl_pkg::IDX_SLOW_CTL, 8'h02);
		repeat (60) @(posedge clk_i);
		rdc(clk_ctrl_pkg::IDX_STATUS, 8'h10);
		periph_request_i <= 4'h2;
		repeat (40) @(posedge clk_i);
		rdc(clk_ctrl_pkg::IDX_STATUS, 8'h30);
		periph_request_i <= 4'h0;
		$display("pin and standby test done");
		pw(clk_ctrl_pkg::IDX_LOCK, 8'h01);
		pw(clk_ctrl_pkg::IDX_CTRL_B, 8'h01);
		rdc(clk_ctrl_pkg::IDX_CTRL_B, {3'h0, cur, 1'b0});
		pw(clk_ctrl_pkg::IDX_FAST_CLA, {2'h0, ~fuse_trim_i});
		rdc(clk_ctrl_pkg::IDX_FAST_CLA, {2'h0, fuse_trim_i});
		pw(clk_ctrl_pkg::IDX_LOCK, 8'h00);
		rdc(clk_ctrl_pkg::IDX_LOCK, 8'h01);
		do_reset();
		rdc(clk_ctrl_pkg::IDX_LOCK, 8'h00);
		rdc(clk_ctrl_pkg::IDX_CTRL_B, 8'h11);
		$display("lock test done");
		close_out();
	end
endmodule
bind main_clock_select_prescale clk_ctrl_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.osc_enable_o(osc_enable_o), .sleep_i(sleep_i), .periph_uses_sysclk_i(periph_uses_sysclk_i),
	.sysclk_pin_out_o(sysclk_pin_out_o), .main_source_o(main_source_o));
`default_nettype wire
